// ==== pkg/dav_pkg.sv ====
package dav_pkg;

   // Register byte offsets of the delta angle and delta velocity words.
   localparam logic [6:0] ANGLE_X_LOWER_OFS = 7'h24;
   localparam logic [6:0] ANGLE_X_UPPER_OFS = 7'h26;
   localparam logic [6:0] ANGLE_Y_LOWER_OFS = 7'h28;
   localparam logic [6:0] ANGLE_Y_UPPER_OFS = 7'h2A;
   localparam logic [6:0] ANGLE_Z_LOWER_OFS = 7'h2C;
   localparam logic [6:0] ANGLE_Z_UPPER_OFS = 7'h2E;
   localparam logic [6:0] VELOCITY_X_LOWER_OFS = 7'h30;
   localparam logic [6:0] VELOCITY_X_UPPER_OFS = 7'h32;
   localparam logic [6:0] VELOCITY_Y_LOWER_OFS = 7'h34;
   localparam logic [6:0] VELOCITY_Y_UPPER_OFS = 7'h36;
   localparam logic [6:0] VELOCITY_Z_LOWER_OFS = 7'h38;
   localparam logic [6:0] VELOCITY_Z_UPPER_OFS = 7'h3A;

   // Field positions of the two halves within a 32-bit result.
   localparam int UPPER_MSB = 31;
   localparam int UPPER_LSB = 16;
   localparam int LOWER_MSB = 15;
   localparam int LOWER_LSB = 0;

   // Reset values.
   localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   // Saturation limits of the 32-bit two's complement result.
   localparam logic [31:0] RESULT_POS_FULL = 32'h7FFF_FFFF;
   localparam logic [31:0] RESULT_NEG_FULL = 32'h8000_0000;

   // Nominal internal sample rate in samples per second.
   localparam int SAMPLE_RATE_SPS = 2000;

   // Scaling: each sample pair is multiplied by a gain and the sum shifted right.
   localparam int ACC_WIDTH = 48;
   localparam int SUM_SHIFT = 8;
   localparam logic [15:0] VELOCITY_GAIN = 16'h8000;
   // Angle gains follow 1/360 : 1/720 : 1/2160 of the maximum delta angle.
   localparam logic [15:0] ANGLE_GAIN_360 = 16'hC000;
   localparam logic [15:0] ANGLE_GAIN_720 = 16'h6000;
   localparam logic [15:0] ANGLE_GAIN_2160 = 16'h2000;

   // Gyroscope range model selection codes.
   localparam logic [1:0] RANGE_360 = 2'h0;
   localparam logic [1:0] RANGE_720 = 2'h1;
   localparam logic [1:0] RANGE_2160 = 2'h2;

   // Axis index within the result array.
   localparam int AX_ANGLE_X = 0;
   localparam int AX_ANGLE_Y = 1;
   localparam int AX_ANGLE_Z = 2;
   localparam int AX_VEL_X = 3;
   localparam int AX_VEL_Y = 4;
   localparam int AX_VEL_Z = 5;
   localparam int NUM_AXES = 6;

   // One set of inertial samples taken on a sample clock tick.
   typedef struct packed {
      logic [15:0] gyro_x;
      logic [15:0] gyro_y;
      logic [15:0] gyro_z;
      logic [15:0] accel_x;
      logic [15:0] accel_y;
      logic [15:0] accel_z;
   } dav_sample_s;

   // Register read request.
   typedef struct packed {
      logic rd_en;
      logic [6:0] addr;
   } dav_read_s;

   // Sequencer states.
   typedef enum logic [1:0] {
      ST_COLLECT = 2'b01,
      ST_PUBLISH = 2'b10
   } dav_state_e;

endpackage : dav_pkg

// ==== rtl/dav_axis.sv ====
`timescale 1ns/10ps
// Trapezoidal integrator for one axis: adds each new sample to the one before it,
// scales the pair by a gain and accumulates it over one decimation period.
module dav_axis
   import dav_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sample_valid,
   input wire logic [15:0] sample,
   input wire logic [15:0] gain,
   input wire logic clear,
   output logic [31:0] result
);

   typedef struct packed {
      logic [15:0] prev;
      logic [ACC_WIDTH-1:0] acc;
   } dav_axis_s;

   dav_axis_s state_q;
   dav_axis_s state_d;
   logic signed [16:0] pair_sum;
   logic signed [33:0] pair_prod;
   logic signed [ACC_WIDTH-1:0] shifted;

   // Pair the sample with the previous one, which carries across period boundaries.
   always_comb
   begin
      state_d = state_q;
      pair_sum = 17'(signed'(sample)) + 17'(signed'(state_q.prev));
      pair_prod = 34'(pair_sum) * signed'({1'b0, gain});
      if (clear)
      begin
         state_d.acc = '0;
      end
      if (sample_valid)
      begin
         state_d.acc = ACC_WIDTH'(signed'(state_d.acc) + ACC_WIDTH'(pair_prod));
         state_d.prev = sample;
      end
   end

   // Scale the running sum and clamp it to the 32-bit code range.
   always_comb
   begin
      shifted = signed'(state_q.acc) >>> SUM_SHIFT;
      if (shifted > ACC_WIDTH'(signed'(RESULT_POS_FULL)))
      begin
         result = RESULT_POS_FULL;
      end
      else if (shifted < ACC_WIDTH'(signed'(RESULT_NEG_FULL)))
      begin
         result = RESULT_NEG_FULL;
      end
      else
      begin
         result = shifted[31:0];
      end
   end

   // State register.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

endmodule : dav_axis

// ==== rtl/dav_top.sv ====
`timescale 1ns/10ps
// Overview of operation
// - Delta velocity per axis is the sum of consecutive acceleration pairs over a period, scaled by 1/(2 fs).
// - One delta result integrates the decimation setting plus one samples.
// - With the internal sample clock the integration assumes 2000 samples per second.
// - A delta velocity result is kept for each of the x, y and z axes.
// - Each result is split into a low and an upper 16-bit word forming one 32-bit two's complement value.
// - The upper velocity word is two's complement over +/-100 m/s with zero as 0x0000.
// - The low velocity word holds 16 further resolution bits below the upper word.
// - The upper angle word is two's complement with zero as 0x0000 and LSB of max angle over 2^15.
// - The low angle word holds bits 15 to 0 of the 32-bit angle result.
// - In 16-bit view 0x7FFF is the largest positive code and 0x8000 is negative full scale.
// - In 32-bit view 0x7FFFFFFF is the largest positive code and 0x80000000 is negative full scale.
// - Delta angle per axis uses the same trapezoidal sum over gyroscope samples.
// - The delta angle full scale is 360, 720 or 2160 degrees by range model.
module dav_top
   import dav_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sample_valid,
   input wire dav_sample_s sample_in,
   input wire logic [15:0] decimation_setting,
   input wire logic [1:0] range_model,
   input wire dav_read_s read_req,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   output logic sample_ready_output
);

   typedef struct packed {
      dav_state_e state;
      logic [15:0] count;
      logic [NUM_AXES-1:0][31:0] res;
      logic [15:0] rdata;
      logic rvalid;
      logic ready;
   } dav_top_s;

   dav_top_s st_q;
   dav_top_s st_d;
   logic [15:0] angle_gain;
   logic clear_acc;
   logic [NUM_AXES-1:0][15:0] axis_sample;
   logic [NUM_AXES-1:0][15:0] axis_gain;
   logic [NUM_AXES-1:0][31:0] axis_result;
   logic [6:0] word_addr;

   // Angle gain follows the gyroscope range model.
   always_comb
   begin
      if (range_model == RANGE_720)
      begin
         angle_gain = ANGLE_GAIN_720;
      end
      else if (range_model == RANGE_2160)
      begin
         angle_gain = ANGLE_GAIN_2160;
      end
      else
      begin
         angle_gain = ANGLE_GAIN_360;
      end
   end

   // Route each axis its sample and gain; velocity gain assumes the nominal rate.
   always_comb
   begin
      axis_sample[AX_ANGLE_X] = sample_in.gyro_x;
      axis_sample[AX_ANGLE_Y] = sample_in.gyro_y;
      axis_sample[AX_ANGLE_Z] = sample_in.gyro_z;
      axis_sample[AX_VEL_X] = sample_in.accel_x;
      axis_sample[AX_VEL_Y] = sample_in.accel_y;
      axis_sample[AX_VEL_Z] = sample_in.accel_z;
      axis_gain[AX_ANGLE_X] = angle_gain;
      axis_gain[AX_ANGLE_Y] = angle_gain;
      axis_gain[AX_ANGLE_Z] = angle_gain;
      axis_gain[AX_VEL_X] = VELOCITY_GAIN;
      axis_gain[AX_VEL_Y] = VELOCITY_GAIN;
      axis_gain[AX_VEL_Z] = VELOCITY_GAIN;
   end

   // The accumulators restart in the cycle the finished sums are published.
   assign clear_acc = (st_q.state == ST_PUBLISH);

   // One integrator per axis, three gyroscope and three accelerometer.
   for (genvar i = 0; i < NUM_AXES; i++)
   begin : g_axis
      dav_axis u_axis (
         .core_clk(core_clk),
         .rst(rst),
         .sample_valid(sample_valid),
         .sample(axis_sample[i]),
         .gain(axis_gain[i]),
         .clear(clear_acc),
         .result(axis_result[i])
      );
   end

   // Sequencer, output result registers and register read port.
   always_comb
   begin
      st_d = st_q;
      st_d.ready = 1'b0;
      st_d.rvalid = 1'b0;
      word_addr = {read_req.addr[6:1], 1'b0};
      case (st_q.state)
         ST_COLLECT:
         begin
            if (sample_valid)
            begin
               if (st_q.count == decimation_setting)
               begin
                  st_d.count = COUNT_RESET;
                  st_d.state = ST_PUBLISH;
               end
               else
               begin
                  st_d.count = 16'(st_q.count + 16'h0001);
               end
            end
         end
         ST_PUBLISH:
         begin
            st_d.res = axis_result;
            st_d.ready = 1'b1;
            st_d.state = ST_COLLECT;
            // A sample in this cycle opens the next period; at decimation zero it also closes that period.
            if (sample_valid)
            begin
               if (decimation_setting == COUNT_RESET)
               begin
                  st_d.state = ST_PUBLISH;
               end
               else
               begin
                  st_d.count = 16'h0001;
               end
            end
         end
         default:
         begin
            st_d.state = ST_COLLECT;
         end
      endcase
      if (read_req.rd_en)
      begin
         st_d.rvalid = 1'b1;
         if (word_addr == ANGLE_X_LOWER_OFS)
         begin
            st_d.rdata = st_q.res[AX_ANGLE_X][LOWER_MSB:LOWER_LSB];
         end
         else if (word_addr == ANGLE_X_UPPER_OFS)
         begin
            st_d.rdata = st_q.res[AX_ANGLE_X][UPPER_MSB:UPPER_LSB];
         end
         else if (word_addr == ANGLE_Y_LOWER_OFS)
         begin
            st_d.rdata = st_q.res[AX_ANGLE_Y][LOWER_MSB:LOWER_LSB];
         end
         else if (word_addr == ANGLE_Y_UPPER_OFS)
         begin
            st_d.rdata = st_q.res[AX_ANGLE_Y][UPPER_MSB:UPPER_LSB];
         end
         else if (word_addr == ANGLE_Z_LOWER_OFS)
         begin
            st_d.rdata = st_q.res[AX_ANGLE_Z][LOWER_MSB:LOWER_LSB];
         end
         else if (word_addr == ANGLE_Z_UPPER_OFS)
         begin
            st_d.rdata = st_q.res[AX_ANGLE_Z][UPPER_MSB:UPPER_LSB];
         end
         else if (word_addr == VELOCITY_X_LOWER_OFS)
         begin
            st_d.rdata = st_q.res[AX_VEL_X][LOWER_MSB:LOWER_LSB];
         end
         else if (word_addr == VELOCITY_X_UPPER_OFS)
         begin
            st_d.rdata = st_q.res[AX_VEL_X][UPPER_MSB:UPPER_LSB];
         end
         else if (word_addr == VELOCITY_Y_LOWER_OFS)
         begin
            st_d.rdata = st_q.res[AX_VEL_Y][LOWER_MSB:LOWER_LSB];
         end
         else if (word_addr == VELOCITY_Y_UPPER_OFS)
         begin
            st_d.rdata = st_q.res[AX_VEL_Y][UPPER_MSB:UPPER_LSB];
         end
         else if (word_addr == VELOCITY_Z_LOWER_OFS)
         begin
            st_d.rdata = st_q.res[AX_VEL_Z][LOWER_MSB:LOWER_LSB];
         end
         else if (word_addr == VELOCITY_Z_UPPER_OFS)
         begin
            st_d.rdata = st_q.res[AX_VEL_Z][UPPER_MSB:UPPER_LSB];
         end
         else
         begin
            st_d.rdata = WORD_RESET;
         end
      end
   end

   // State register.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_q.state <= ST_COLLECT;
         st_q.count <= COUNT_RESET;
         st_q.res <= {NUM_AXES{RESULT_RESET}};
         st_q.rdata <= WORD_RESET;
         st_q.rvalid <= 1'b0;
         st_q.ready <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign reg_rdata = st_q.rdata;
   assign reg_rvalid = st_q.rvalid;
   assign sample_ready_output = st_q.ready;

endmodule : dav_top

// ==== tb/dav_host.sv ====
`timescale 1ns/10ps
// Host side of the register read port.
module dav_host
   import dav_pkg::*;
(
   input wire logic core_clk,
   output dav_read_s read_req,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid
);
   // The port is idle from time zero.
   initial read_req = '0;

   // Issues one read strobe; the address is inverted after release so stale decoding shows.
   task rd(input logic [6:0] a, output logic [15:0] d);
      @(posedge core_clk);
      read_req <= '{1'b1, a};
      @(posedge core_clk);
      read_req <= '{1'b0, ~a};
      @(negedge core_clk);
      d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
   endtask : rd
endmodule : dav_host

// ==== tb/dav_top_sva.sv ====
`timescale 1ns/10ps
// Checks the timing of the sample and read paths at the ports of the top module.
module dav_top_sva
   import dav_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sample_valid,
   input wire logic [15:0] decimation_setting,
   input wire dav_read_s read_req,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic sample_ready_output
);
   logic [15:0] cnt_q;
   logic last;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Marks the sample that closes a decimation period.
   assign last = sample_valid && (cnt_q == decimation_setting);

   // Counts the samples taken so far in the current period.
   always_ff @(posedge core_clk)
   begin
      if (rst || last)
      begin
         cnt_q <= 16'h0000;
      end
      else if (sample_valid)
      begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   a_ready_after_last: assert property (last |-> ##2 sample_ready_output)
      else $error("ready pulse missing after last sample");
   a_ready_has_cause: assert property (sample_ready_output |-> $past(last, 2))
      else $error("ready pulse without a closing sample");
   a_ready_one_cycle: assert property (sample_ready_output && decimation_setting != 16'h0000 |=> !sample_ready_output)
      else $error("ready pulse longer than one cycle");
   a_idle_no_ready: assert property (!sample_valid [*3] |-> !sample_ready_output)
      else $error("ready pulse with no recent sample");
   a_read_answer: assert property (read_req.rd_en |=> reg_rvalid)
      else $error("read not answered in one cycle");
   a_read_has_cause: assert property (reg_rvalid |-> $past(read_req.rd_en))
      else $error("read answer without a request");
   a_unmapped_zero: assert property (read_req.rd_en && (read_req.addr < 7'h24 || read_req.addr > 7'h3B)
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!read_req.rd_en |=> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule : dav_top_sva

bind dav_top dav_top_sva i_dav_top_sva (.core_clk(core_clk), .rst(rst), .sample_valid(sample_valid),
   .decimation_setting(decimation_setting), .read_req(read_req), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .sample_ready_output(sample_ready_output));

// ==== tb/dav_top_test.sv ====
`timescale 1ns/10ps
// Self-checking bench for the delta angle and delta velocity outputs.
module dav_top_test
   import dav_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic sample_valid = 1'b0;
   dav_sample_s sample_in = '0;
   logic [15:0] decimation_setting = 16'h0000;
   logic [1:0] range_model = RANGE_360;
   dav_read_s read_req;
   logic [15:0] reg_rdata;
   logic reg_rvalid;
   logic sample_ready_output;
   int fail_count = 0;
   int comparisons = 0;
   int ready_seen = 0;
   logic signed [47:0] acc [6];
   logic [15:0] prv [6];
   logic [31:0] expv [6];

   dav_top i_dav_top (.core_clk(core_clk), .rst(rst), .sample_valid(sample_valid), .sample_in(sample_in),
      .decimation_setting(decimation_setting), .range_model(range_model), .read_req(read_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_ready_output(sample_ready_output));
   dav_host i_dav_host (.core_clk(core_clk), .read_req(read_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   // Makes the 200 MHz clock.
   initial forever #2.5 core_clk = ~core_clk;

   // Counts ready pulses at the falling edge, where they are settled.
   always @(negedge core_clk)
   begin
      if (sample_ready_output === 1'b1)
      begin
         ready_seen++;
      end
   end

   // Compares one result and counts it.
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // Prints the verdict and ends the run.
   task test_done;
      if (fail_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   // Gain of one axis for the selected range model.
   function logic [15:0] gain(input int i);
      if (i >= AX_VEL_X) return VELOCITY_GAIN;
      if (range_model == RANGE_720) return ANGLE_GAIN_720;
      if (range_model == RANGE_2160) return ANGLE_GAIN_2160;
      return ANGLE_GAIN_360;
   endfunction : gain

   // Integrates one sample set in the model; a closing sample also forms the expected results.
   task mdl(input dav_sample_s s, input logic last);
      logic [15:0] w;
      logic signed [47:0] v;
      for (int i = 0; i < NUM_AXES; i++)
      begin
         w = s[95 - 16 * i -: 16];
         v = $signed({{32{w[15]}}, w}) + $signed({{32{prv[i][15]}}, prv[i]});
         acc[i] = acc[i] + v * $signed({32'h0000_0000, gain(i)});
         prv[i] = w;
         if (last)
         begin
            v = acc[i] >>> 8;
            expv[i] = (&v[47:31] || ~|v[47:31]) ? v[31:0] : (v[47] ? RESULT_NEG_FULL : RESULT_POS_FULL);
            acc[i] = '0;
         end
      end
   endtask : mdl

   // Sends one sample set; a closing sample also checks the ready pulse, which stands two cycles later.
   task smp(input dav_sample_s s, input logic last);
      @(posedge core_clk);
      sample_valid <= 1'b1;
      sample_in <= s;
      mdl(s, last);
      @(posedge core_clk);
      sample_valid <= 1'b0;
      if (last)
      begin
         @(posedge core_clk);
         @(negedge core_clk);
         cmp(sample_ready_output, 32'h0000_0001);
      end
   endtask : smp

   // Reads both words of every axis and compares them with the model.
   task chk_all;
      logic [15:0] d;
      for (int i = 0; i < NUM_AXES; i++)
      begin
         i_dav_host.rd(ANGLE_X_LOWER_OFS + 7'(4 * i), d);
         cmp(d, expv[i][15:0]);
         i_dav_host.rd(ANGLE_X_UPPER_OFS + 7'(4 * i), d);
         cmp(d, expv[i][31:16]);
      end
   endtask : chk_all

   // Checks cleared results and an unmapped read after reset.
   task t_reset;
      logic [15:0] d;
      chk_all;
      i_dav_host.rd(7'h40, d);
      cmp(d, 32'h0000_0000);
   endtask : t_reset

   // One-sample period with mixed signs on every axis.
   task t_single;
      smp('{16'h0001, 16'h7FFF, 16'hFFFF, 16'h0300, 16'h8000, 16'h1234}, 1'b1);
      chk_all;
   endtask : t_single

   // Three-sample period.
   task t_decim;
      @(posedge core_clk);
      decimation_setting <= 16'h0002;
      smp('{16'h0010, 16'hFFF0, 16'h0100, 16'hFF00, 16'h0001, 16'h2000}, 1'b0);
      smp('{16'h0020, 16'hFFE0, 16'h0200, 16'hFE00, 16'h0002, 16'h1000}, 1'b0);
      smp('{16'h0030, 16'hFFD0, 16'h0300, 16'hFD00, 16'h0003, 16'h0800}, 1'b1);
      chk_all;
   endtask : t_decim

   // Every range model scales the angle results.
   task t_ranges;
      for (int r = 0; r < 4; r++)
      begin
         @(posedge core_clk);
         range_model <= 2'(r);
         decimation_setting <= 16'h0000;
         smp('{16'h0400, 16'hFC00, 16'h0123, 16'h0001, 16'h0002, 16'h0003}, 1'b1);
         chk_all;
      end
   endtask : t_ranges

   // A long period drives all three angle results into saturation.
   task t_sat;
      @(posedge core_clk);
      range_model <= RANGE_360;
      decimation_setting <= 16'h00C7;
      repeat (199) smp('{16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h0000}, 1'b0);
      smp('{16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h0000}, 1'b1);
      chk_all;
   endtask : t_sat

   // Back-to-back samples at decimation zero give one ready pulse each, so the host can measure the rate.
   task t_rate;
      int n0;
      n0 = ready_seen;
      @(posedge core_clk);
      decimation_setting <= 16'h0000;
      sample_valid <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         mdl(sample_in, 1'b1);
         @(posedge core_clk);
      end
      sample_valid <= 1'b0;
      repeat (4) @(posedge core_clk);
      cmp(32'(ready_seen - n0), 32'h0000_0004);
      chk_all;
   endtask : t_rate

   // Clears the model, releases reset and runs the scenarios.
   initial
   begin
      for (int i = 0; i < NUM_AXES; i++)
      begin
         acc[i] = '0;
         prv[i] = '0;
         expv[i] = '0;
      end
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_reset;
      t_single;
      t_decim;
      t_ranges;
      t_sat;
      t_rate;
      repeat (4) @(posedge core_clk);
      test_done;
   end

   // Cuts a hang short.
   initial
   begin
      repeat (5000) @(posedge core_clk);
      fail_count++;
      test_done;
   end
endmodule : dav_top_test
